// ---- include/timer_mode_pkg.sv ----
// Shared constants for the timer mode and function control block
package timer_mode_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int REG_W  = 8;
   localparam int CNT_W  = 16;
   localparam int NCH    = 5;
   localparam int MEN_W  = 6;
   localparam int BUF_W  = 4;

   // ----------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] MODE_OFS = 8'h00;
   localparam logic [ADDR_W-1:0] FUNC_OFS = 8'h04;
   localparam logic [ADDR_W-1:0] MEN_OFS  = 8'h08;
   localparam logic [ADDR_W-1:0] OCTL_OFS = 8'h0C;
   localparam logic [ADDR_W-1:0] SYNC_OFS = 8'h10;
   localparam logic [ADDR_W-1:0] CNT_OFS  = 8'h14;
   localparam logic [ADDR_W-1:0] STAT_OFS = 8'h18;

   // ----------------------------------------------------------------
   // Reset values and bits that always read as one
   // ----------------------------------------------------------------
   localparam logic [REG_W-1:0] MODE_RST   = 8'h80;
   localparam logic [REG_W-1:0] MODE_FIXED = 8'h80;
   localparam logic [REG_W-1:0] FUNC_RST   = 8'hC0;
   localparam logic [REG_W-1:0] FUNC_FIXED = 8'hC0;
   localparam logic [REG_W-1:0] MEN_RST    = 8'hFF;
   localparam logic [REG_W-1:0] MEN_FIXED  = 8'hC0;
   localparam logic [REG_W-1:0] MEN_CLR    = 8'h3F;
   localparam logic [REG_W-1:0] OCTL_RST   = 8'hFF;
   localparam logic [REG_W-1:0] OCTL_FIXED = 8'hEF;
   localparam logic [REG_W-1:0] SYNC_RST   = 8'hE0;
   localparam logic [REG_W-1:0] SYNC_FIXED = 8'hE0;
   localparam logic [CNT_W-1:0] CNT_ZERO   = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE    = 16'h0001;
   localparam logic [CNT_W-1:0] CNT_MAX    = 16'hFFFF;
   localparam logic [NCH-1:0]   COMB_PWM_MASK = 5'h18;
   localparam logic [NCH-1:0]   NO_PWM_MASK   = 5'h00;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int PHASE_BIT = 6;
   localparam int FLAG_DIRECTION_BIT  = 5;
   localparam int COMB_HI   = 5;
   localparam int COMB_LO   = 4;
   localparam int ENABLE_COMP_B_CH4_BIT  = 5;
   localparam int EXT_TRIGGER_DISABLE_BIT  = 4;
   localparam int OVF_BIT   = 0;

   typedef enum logic [1:0] {
      COMB_NORMAL0 = 2'b00,
      COMB_NORMAL1 = 2'b01,
      COMB_COMPL   = 2'b10,
      COMB_RSYNC   = 2'b11
   } comb_e;

endpackage

// ---- include/quad_if.sv ----
// Count pulses from the quadrature decoder to the channel 2 counter
`timescale 1ns/100ps
interface quad_if;
   logic count_up;
   logic count_dn;
   modport source (output count_up, output count_dn);
   modport sink   (input  count_up, input  count_dn);
endinterface

// ---- logic/quad_decoder.sv ----
// Quadrature edge decoder for the channel 2 phase counting inputs
`timescale 1ns/100ps
module quad_decoder (
   input  logic  pclk,
   input  logic  presetn,
   input  logic  quad_input_a,
   input  logic  quad_input_b,
   quad_if.source q
);

   // ----------------------------------------------------------------
   // Synchronisers and edge history
   // ----------------------------------------------------------------
   logic a_meta_r;
   logic a_sync_r;
   logic a_prev_r;
   logic b_meta_r;
   logic b_sync_r;
   logic b_prev_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         a_meta_r <= 1'b0;
         a_sync_r <= 1'b0;
         a_prev_r <= 1'b0;
         b_meta_r <= 1'b0;
         b_sync_r <= 1'b0;
         b_prev_r <= 1'b0;
      end else begin
         a_meta_r <= quad_input_a;
         a_sync_r <= a_meta_r;
         a_prev_r <= a_sync_r;
         b_meta_r <= quad_input_b;
         b_sync_r <= b_meta_r;
         b_prev_r <= b_sync_r;
      end
   end

   // ----------------------------------------------------------------
   // Direction decode
   // ----------------------------------------------------------------
   wire a_rise = a_sync_r & ~a_prev_r;
   wire a_fall = ~a_sync_r & a_prev_r;
   wire b_rise = b_sync_r & ~b_prev_r;
   wire b_fall = ~b_sync_r & b_prev_r;

   // Both edges of both inputs count
   wire dn_a = (a_rise & ~b_sync_r) | (a_fall & b_sync_r);
   wire up_a = (a_rise & b_sync_r) | (a_fall & ~b_sync_r);
   wire dn_b = (b_rise & a_sync_r) | (b_fall & ~a_sync_r);
   wire up_b = (b_rise & ~a_sync_r) | (b_fall & a_sync_r);
   wire dn_any = dn_a | dn_b;
   wire up_any = up_a | up_b;

   // Both inputs moving in one cycle is a lost phase: count nothing
   assign q.count_up = up_any & ~dn_any;
   assign q.count_dn = dn_any & ~up_any;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_single_edge: assert property (
      (a_sync_r != a_prev_r) && (b_sync_r == b_prev_r)
         |-> (q.count_up ^ q.count_dn))
      else $error("Lone quadrature edge gave no single count pulse");

endmodule // quad_decoder

// ---- logic/timer_mode_ctrl.sv ----
// Mode, function and output master enable control of the timer unit
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/100ps
// Behaviour
// - Mode register resets to 80, bit 7 fixed
// - Phase select turns counter 2 up/down
// - Both edges of both inputs counted
// - Input B leading A counts up, A leading B counts down
// - Phase mode overrides clock and prescale choice
// - Clear and flags keep working in phase mode
// - Flag direction picks overflow or both
// - PWM bit: set on A, clear on B
// - Combined modes ignore channel 3/4 PWM bits
// - Function register resets to C0, top fixed
// - Combination field picks normal, complementary, reset-sync
// - Sync selections stay valid in combined modes
// - Four bits enable general register buffering
// - Master enable resets to FF, top fixed
// - Enable bit 5 gates complementary B output
// - Channel 1 capture A clears bits 5 to 0
// - Trigger disable blocks clearing, combined only
module timer_mode_ctrl (
   input  logic                                  pclk,
   input  logic                                  presetn,
   input  logic                                  standby,
   input  logic [timer_mode_pkg::ADDR_W-1:0]     paddr,
   input  logic                                  psel,
   input  logic                                  penable,
   input  logic                                  pwrite,
   input  logic [timer_mode_pkg::DATA_W-1:0]     pwdata,
   output logic [timer_mode_pkg::DATA_W-1:0]     prdata,
   output logic                                  pready,
   output logic                                  pslverr,
   input  logic                                  quad_input_a,
   input  logic                                  quad_input_b,
   input  logic                                  run_ch2,
   input  logic                                  count_tick_ch2,
   input  logic                                  clear_ch2,
   input  logic [timer_mode_pkg::NCH-1:0]        cmp_match_a,
   input  logic [timer_mode_pkg::NCH-1:0]        cmp_match_b,
   input  logic                                  capture_a_ch1,
   output logic [timer_mode_pkg::NCH-1:0]        output_a,
   output logic [timer_mode_pkg::NCH-1:0]        pwm_active,
   output logic                                  phase_mode,
   output timer_mode_pkg::comb_e                 combination_mode,
   output logic [timer_mode_pkg::BUF_W-1:0]      buffer_mode,
   output logic [timer_mode_pkg::NCH-1:0]        channel_sync_select,
   output logic [timer_mode_pkg::MEN_W-1:0]      master_enable,
   output logic                                  comp_output_b_ch4_en,
   output logic [timer_mode_pkg::CNT_W-1:0]      counter_ch2,
   output logic                                  overflow_flag
);
   import timer_mode_pkg::*;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [REG_W-1:0]  timer_mode_select_r;
   logic [REG_W-1:0]  combined_function_control_r;
   logic [REG_W-1:0]  output_master_enable_r;
   logic [REG_W-1:0]  output_control_r;
   logic [REG_W-1:0]  sync_select_r;
   logic [CNT_W-1:0]  counter_ch2_r;
   logic              overflow_flag_r;
   logic [NCH-1:0]    output_a_r;
   logic [DATA_W-1:0] prdata_r;

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   wire access   = psel & penable;
   wire setup_rd = psel & ~penable & ~pwrite;
   wire wr       = access & pwrite;
   wire hit_mode = (paddr == MODE_OFS);
   wire hit_func = (paddr == FUNC_OFS);
   wire hit_men  = (paddr == MEN_OFS);
   wire hit_octl = (paddr == OCTL_OFS);
   wire hit_sync = (paddr == SYNC_OFS);
   wire hit_cnt  = (paddr == CNT_OFS);
   wire hit_stat = (paddr == STAT_OFS);
   wire hit_any  = hit_mode | hit_func | hit_men | hit_octl |
                   hit_sync | hit_cnt | hit_stat;
   wire wr_mode  = wr & hit_mode;
   wire wr_func  = wr & hit_func;
   wire wr_men   = wr & hit_men;
   wire wr_octl  = wr & hit_octl;
   wire wr_sync  = wr & hit_sync;
   wire wr_cnt   = wr & hit_cnt;
   wire wr_stat  = wr & hit_stat;

   // Zero wait states keep the slave simple; read data is caught in setup
   assign pready  = 1'b1;
   assign pslverr = access & ~hit_any;

   wire [REG_W-1:0] wbyte = pwdata[REG_W-1:0];
   wire [DATA_W-1:0] rd_mux =
      hit_mode ? {24'h000000, timer_mode_select_r} :
      hit_func ? {24'h000000, combined_function_control_r} :
      hit_men  ? {24'h000000, output_master_enable_r} :
      hit_octl ? {24'h000000, output_control_r} :
      hit_sync ? {24'h000000, sync_select_r} :
      hit_cnt  ? {16'h0000, counter_ch2_r} :
      hit_stat ? {31'h00000000, overflow_flag_r} :
                 32'h00000000;

   // ----------------------------------------------------------------
   // Mode field decode
   // ----------------------------------------------------------------
   wire   phase_sel = timer_mode_select_r[PHASE_BIT];
   wire   flag_direction      = timer_mode_select_r[FLAG_DIRECTION_BIT];
   comb_e comb;
   assign comb = comb_e'(combined_function_control_r[COMB_HI:COMB_LO]);
   wire   combined  = (comb == COMB_COMPL) || (comb == COMB_RSYNC);
   wire   ext_trigger_disable      = output_control_r[EXT_TRIGGER_DISABLE_BIT];
   // External trigger only acts in the combined modes
   wire   hw_clear  = capture_a_ch1 & combined & ~ext_trigger_disable;

   // ----------------------------------------------------------------
   // Control register next values
   // ----------------------------------------------------------------
   // Fixed bits are forced on every write, so they can never drop
   wire [REG_W-1:0] mode_nxt =
      standby ? MODE_RST :
      wr_mode ? (wbyte | MODE_FIXED) : timer_mode_select_r;
   wire [REG_W-1:0] func_nxt =
      standby ? FUNC_RST :
      wr_func ? (wbyte | FUNC_FIXED) : combined_function_control_r;
   wire [REG_W-1:0] men_base =
      standby ? MEN_RST :
      wr_men  ? (wbyte | MEN_FIXED) : output_master_enable_r;
   // Hardware clear beats a write landing in the same cycle
   wire [REG_W-1:0] men_nxt =
      (hw_clear & ~standby) ? (men_base & ~MEN_CLR) : men_base;
   wire [REG_W-1:0] octl_nxt =
      standby ? OCTL_RST :
      wr_octl ? (wbyte | OCTL_FIXED) : output_control_r;
   wire [REG_W-1:0] sync_nxt =
      standby ? SYNC_RST :
      wr_sync ? (wbyte | SYNC_FIXED) : sync_select_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_mode_select_r         <= MODE_RST;
         combined_function_control_r <= FUNC_RST;
         output_master_enable_r      <= MEN_RST;
         output_control_r            <= OCTL_RST;
         sync_select_r               <= SYNC_RST;
      end else begin
         timer_mode_select_r         <= mode_nxt;
         combined_function_control_r <= func_nxt;
         output_master_enable_r      <= men_nxt;
         output_control_r            <= octl_nxt;
         sync_select_r               <= sync_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Channel 2 counter
   // ----------------------------------------------------------------
   quad_if qd ();

   quad_decoder u_quad (
      .pclk         (pclk),
      .presetn      (presetn),
      .quad_input_a (quad_input_a),
      .quad_input_b (quad_input_b),
      .q            (qd.source)
   );

   // Clear and software load stay in force in every mode
   wire cnt_hold = standby | wr_cnt | clear_ch2;
   // Phase mode takes the decoder and drops the prescaled tick
   wire cnt_up = run_ch2 & ~cnt_hold &
                 (phase_sel ? qd.count_up : count_tick_ch2);
   wire cnt_dn = run_ch2 & ~cnt_hold & phase_sel & qd.count_dn;
   wire ovf_evt = cnt_up & (counter_ch2_r == CNT_MAX);
   wire unf_evt = cnt_dn & (counter_ch2_r == CNT_ZERO);
   wire ovf_set = ovf_evt | (unf_evt & ~flag_direction);

   wire [CNT_W-1:0] cnt_nxt =
      standby   ? CNT_ZERO :
      wr_cnt    ? pwdata[CNT_W-1:0] :
      clear_ch2 ? CNT_ZERO :
      cnt_up    ? counter_ch2_r + CNT_ONE :
      cnt_dn    ? counter_ch2_r - CNT_ONE : counter_ch2_r;
   // Write zero clears; a set in the same cycle still wins
   wire ovf_nxt =
      standby ? 1'b0 :
      ovf_set ? 1'b1 :
      (wr_stat & ~pwdata[OVF_BIT]) ? 1'b0 : overflow_flag_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         counter_ch2_r   <= CNT_ZERO;
         overflow_flag_r <= 1'b0;
      end else begin
         counter_ch2_r   <= cnt_nxt;
         overflow_flag_r <= ovf_nxt;
      end
   end

   // ----------------------------------------------------------------
   // PWM outputs
   // ----------------------------------------------------------------
   wire [NCH-1:0] pwm_sel =
      timer_mode_select_r[NCH-1:0] &
      ~(combined ? COMB_PWM_MASK : NO_PWM_MASK);
   logic [NCH-1:0] out_nxt;

   // Match B wins a tie, so an equal pair of registers gives a low pin
   genvar n;
   generate
      for (n = 0; n < NCH; n++) begin : g_pwm
         assign out_nxt[n] =
            standby                      ? 1'b0 :
            (pwm_sel[n] & cmp_match_b[n]) ? 1'b0 :
            (pwm_sel[n] & cmp_match_a[n]) ? 1'b1 : output_a_r[n];
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         output_a_r <= NO_PWM_MASK;
         prdata_r   <= 32'h00000000;
      end else begin
         output_a_r <= out_nxt;
         if (setup_rd) begin
            prdata_r <= rd_mux;
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata               = prdata_r;
   assign output_a             = output_a_r;
   assign pwm_active           = pwm_sel;
   assign phase_mode           = phase_sel;
   assign combination_mode     = comb;
   assign buffer_mode          = combined_function_control_r[BUF_W-1:0];
   // Sync choices pass through untouched by the combination field
   assign channel_sync_select  = sync_select_r[NCH-1:0];
   assign master_enable        = output_master_enable_r[MEN_W-1:0];
   assign comp_output_b_ch4_en =
      output_master_enable_r[ENABLE_COMP_B_CH4_BIT] & combined;
   assign counter_ch2          = counter_ch2_r;
   assign overflow_flag        = overflow_flag_r;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_wr_mode;
      wr_mode && !standby;
   endsequence

   sequence s_trigger;
      capture_a_ch1 && combined && !ext_trigger_disable && !standby;
   endsequence

   sequence s_step_up;
      run_ch2 && phase_sel && qd.count_up && !cnt_hold;
   endsequence

   a_mode_top_one: assert property (
      (timer_mode_select_r & MODE_FIXED) == MODE_FIXED and
      (standby |=> timer_mode_select_r == MODE_RST))
      else $error("Mode register top bit or standby value wrong");

   a_mode_write: assert property (
      s_wr_mode |=> timer_mode_select_r == ($past(wbyte) | 8'h80))
      else $error("Mode write not seen on next cycle");

   a_func_fixed: assert property (
      (combined_function_control_r & FUNC_FIXED) == FUNC_FIXED and
      (standby |=> combined_function_control_r == FUNC_RST))
      else $error("Function register fixed bits or standby wrong");

   a_men_fixed: assert property (
      (output_master_enable_r & MEN_FIXED) == MEN_FIXED and
      (standby |=> output_master_enable_r == MEN_RST))
      else $error("Master enable fixed bits or standby wrong");

   a_phase_up: assert property (
      s_step_up |=> counter_ch2_r == $past(counter_ch2_r) + 16'h0001)
      else $error("Phase count up step missing");

   a_phase_no_tick: assert property (
      run_ch2 && phase_sel && count_tick_ch2 && !qd.count_up &&
      !qd.count_dn && !cnt_hold |=> $stable(counter_ch2_r))
      else $error("Prescaled tick counted in phase mode");

   a_clear_phase: assert property (
      clear_ch2 && phase_sel && !wr_cnt && !standby
         |=> counter_ch2_r == 16'h0000)
      else $error("Counter clear ignored in phase mode");

   a_ovf_underflow: assert property (
      unf_evt |=> overflow_flag_r == !$past(flag_direction) || $past(overflow_flag_r))
      else $error("Underflow flag setting ignores flag direction");

   a_pwm_rise: assert property (
      pwm_sel[0] && cmp_match_a[0] && !cmp_match_b[0] && !standby
         |=> output_a[0] ##1
             (output_a[0] || $past(cmp_match_b[0]) || $past(standby)))
      else $error("PWM output did not rise on match A");

   a_comb_no_pwm: assert property (
      combined |-> !pwm_active[3] && !pwm_active[4])
      else $error("Channel 3/4 PWM active in combined mode");

   a_trig_clear: assert property (
      s_trigger |=> output_master_enable_r[5:0] == 6'h00 &&
                    !comp_output_b_ch4_en)
      else $error("External trigger did not clear master enables");

   a_ext_trigger_disable_block: assert property (
      capture_a_ch1 && (ext_trigger_disable || !combined) && !wr_men && !standby
         |=> $stable(output_master_enable_r))
      else $error("Blocked trigger still changed master enables");

   a_clear_wins: assert property (
      hw_clear && wr_men && !standby
         |=> (output_master_enable_r & MEN_CLR) == '0)
      else $error("Software write beat the external trigger clear");

   a_comp_b_gate: assert property (
      !output_master_enable_r[ENABLE_COMP_B_CH4_BIT] |-> !comp_output_b_ch4_en)
      else $error("Complementary B output on while its enable is off");

   a_normal_tick: assert property (
      run_ch2 && !phase_sel && count_tick_ch2 && !cnt_hold
         |=> counter_ch2_r == $past(counter_ch2_r) + CNT_ONE)
      else $error("Normal mode tick did not count up");

   a_func_write: assert property (
      wr_func && !standby
         |=> combined_function_control_r == ($past(wbyte) | FUNC_FIXED))
      else $error("Function write not seen on next cycle");

endmodule // timer_mode_ctrl

// ---- sim/quad_encoder_model.sv ----
// Quadrature encoder model feeding the channel 2 phase counting pins
`timescale 1ns/100ps
module quad_encoder_model (
   input  wire logic pclk,
   output logic      quad_input_a,
   output logic      quad_input_b
);
   logic [1:0] pos_r = 2'b00;

   // ------------------------------------------------------------
   // Gray order 00,01,11,10 of (a,b) runs the up direction
   // ------------------------------------------------------------
   assign quad_input_a = pos_r[1];
   assign quad_input_b = pos_r[1] ^ pos_r[0];

   // Only one pin moves per step, so no step looks like a glitch
   task automatic step(input logic up, input int gap);
      @(posedge pclk);
      pos_r <= up ? pos_r + 2'd1 : pos_r - 2'd1;
      repeat (gap) @(posedge pclk);
   endtask
endmodule // quad_encoder_model

// ---- sim/tb_top.sv ----
// Self-checking bench of the timer mode and function control block
`timescale 1ns/100ps
module tb_top;
   import timer_mode_pkg::*;
   logic        pclk = 1'b0, presetn = 1'b0, standby = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, err, qa, qb, phase_mode, comp_en, ovf;
   logic        run_ch2 = 1'b0, tick = 1'b0, clr = 1'b0, cap = 1'b0;
   logic [4:0]  cma = 5'h00, cmb = 5'h00, output_a, pwm_active, sync_sel;
   logic [3:0]  buffer_mode;
   logic [5:0]  master_enable;
   logic [15:0] counter_ch2;
   comb_e       comb_mode;
   int          bad_count = 0, check_count = 0;
   logic [7:0]  rst_v [3] = '{8'h80, 8'hC0, 8'hFF};
   logic [7:0]  fix_v [3] = '{8'h80, 8'hC0, 8'hC0};

   always #5 pclk = ~pclk;

   quad_encoder_model i_quad_encoder_model (.pclk(pclk),
      .quad_input_a(qa), .quad_input_b(qb));

   timer_mode_ctrl i_timer_mode_ctrl (.pclk(pclk), .presetn(presetn),
      .standby(standby), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .quad_input_a(qa),
      .quad_input_b(qb), .run_ch2(run_ch2), .count_tick_ch2(tick),
      .clear_ch2(clr), .cmp_match_a(cma), .cmp_match_b(cmb),
      .capture_a_ch1(cap), .output_a(output_a), .pwm_active(pwm_active),
      .phase_mode(phase_mode), .combination_mode(comb_mode),
      .buffer_mode(buffer_mode), .channel_sync_select(sync_sel),
      .master_enable(master_enable), .comp_output_b_ch4_en(comp_en),
      .counter_ch2(counter_ch2), .overflow_flag(ovf));

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One APB transfer; read data and error taken at the pready edge
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      #1;
   endtask

   task automatic ev(input logic [4:0] a, b, input logic c, k);
      @(posedge pclk);
      cma <= a; cmb <= b; cap <= c; clr <= k;
      @(posedge pclk);
      cma <= 5'h00; cmb <= 5'h00; cap <= 1'b0; clr <= 1'b0;
      #1;
   endtask

   task automatic q(input logic up, input int n);
      repeat (n) i_quad_encoder_model.step(up, 8);
      #1;
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   // Whole sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge pclk);
      bad_count++;
      test_done();
   end

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         xfer(1'b0, 8'(4 * i), 32'h0);
         chk(rd, rst_v[i]);
         xfer(1'b1, 8'(4 * i), 32'h0);
         xfer(1'b0, 8'(4 * i), 32'h0);
         chk(rd, fix_v[i]);
      end
      xfer(1'b0, 8'hFC, 32'h0);
      chk(err, 1'b1);
      chk(rd, 32'h0);
      xfer(1'b1, MODE_OFS, 32'h1F);
      ev(5'h1F, 5'h00, 1'b0, 1'b0);
      chk(output_a, 5'h1F);
      ev(5'h00, 5'h1F, 1'b0, 1'b0);
      chk(output_a, 5'h00);
      for (int c = 0; c < 4; c++) begin
         xfer(1'b1, FUNC_OFS, 32'(c * 16 + 10));
         chk(comb_mode, c);
         chk(pwm_active, c > 1 ? 5'h07 : 5'h1F);
         chk(buffer_mode, 4'hA);
      end
      xfer(1'b1, MEN_OFS, 32'hFF);
      xfer(1'b1, SYNC_OFS, 32'h18);
      chk(sync_sel, 5'h18);
      chk(comp_en, 1'b1);
      xfer(1'b1, OCTL_OFS, 32'hEF);
      ev(5'h00, 5'h00, 1'b1, 1'b0);
      chk(master_enable, 6'h00);
      chk(comp_en, 1'b0);
      // Trigger and a master enable write land on one edge
      fork
         xfer(1'b1, MEN_OFS, 32'hFF);
         begin
            repeat (2) @(posedge pclk);
            cap <= 1'b1;
            @(posedge pclk);
            cap <= 1'b0;
         end
      join
      chk(master_enable, 6'h00);
      xfer(1'b1, MEN_OFS, 32'hFF);
      xfer(1'b1, OCTL_OFS, 32'hFF);
      ev(5'h00, 5'h00, 1'b1, 1'b0);
      chk(master_enable, 6'h3F);
      xfer(1'b1, FUNC_OFS, 32'h0);
      xfer(1'b1, OCTL_OFS, 32'hEF);
      ev(5'h00, 5'h00, 1'b1, 1'b0);
      chk(master_enable, 6'h3F);
      xfer(1'b1, MODE_OFS, 32'h40);
      chk(phase_mode, 1'b1);
      // Tick held high: phase mode must not count it
      @(posedge pclk);
      run_ch2 <= 1'b1; tick <= 1'b1;
      q(1'b0, 1);
      chk(counter_ch2, 16'hFFFF);
      chk(ovf, 1'b1);
      xfer(1'b1, STAT_OFS, 32'h0);
      q(1'b1, 4);
      chk(counter_ch2, 16'h0003);
      chk(ovf, 1'b1);
      ev(5'h00, 5'h00, 1'b0, 1'b1);
      chk(counter_ch2, 16'h0000);
      xfer(1'b1, STAT_OFS, 32'h0);
      xfer(1'b1, MODE_OFS, 32'h60);
      q(1'b0, 1);
      chk(counter_ch2, 16'hFFFF);
      chk(ovf, 1'b0);
      @(posedge pclk);
      standby <= 1'b1;
      @(posedge pclk);
      standby <= 1'b0;
      xfer(1'b0, MODE_OFS, 32'h0);
      chk(rd, 32'h80);
      test_done();
   end
endmodule // tb_top
